// >>> tapid_top.sv
// Test access port controller with instruction decode and debug exchange registers
//
// Behaviour
// R1 - Four pins only; reset reached without reset pin
// R2 - All state steps on scan clock edges
// R3 - Mode select sampled on scan clock rise
// R4 - Serial input sampled on scan clock rise
// R5 - Output follows input after register length
// R6 - Serial output changes on falling edges only
// R7 - Output enabled only while shifting
// R8 - Mode-driven FSM with capture, shift, update
// R9 - Reset state held while mode high
// R10 - Instruction chooses data register in path
// R11 - Parallel stage changes only at update
// R12 - Capture, shift n bits, then update
// R13 - Read-only registers ignore update
// R14 - Handshake bits: zero remembers, one acts; the sleepless bit takes the written value, so zero clears it
// R15 - Five-bit instruction; unlisted opcodes undefined
// R16 - Boundary ops dummy register; all-ones bypass
// R17 - Reset opcode resets whole core
// R18 - Word in, word out, flag-plus-in select
// R19 - Flag-plus-out and handshake control select
// R20 - Test mode and private opcodes decoded
// R21 - Instruction capture loads 01 and control
// R22 - Two 32-bit words in scan path
// R23 - Bypass is one stage capturing zero
`timescale 1ns/1ps
`default_nettype none
module tapid_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  input  wire logic [31:0] core_out_word_i,
  input  wire logic        core_out_word_we_i,
  input  wire logic        core_ofull_set_i,
  input  wire logic        core_ifull_clr_i,
  input  wire logic        core_sleepless_i,
  input  wire logic        core_sleepless_we_i,
  output logic      [31:0] host_in_word_o,
  output logic      [31:0] core_out_word_o,
  output logic             ifull_o,
  output logic             ofull_o,
  output logic             sleepless_o,
  output logic             host_irq_o,
  output logic             core_reset_o,
  output logic             hardware_test_select_o,
  output logic             private_stress_op_o
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                     tck_prev;
    tapid_pkg::tapid_state_t  st;
    logic [4:0]               ir_sh;
    logic [4:0]               ir;
    logic [32:0]              dr_sh;
    logic [31:0]              h2c;
    logic [31:0]              c2h;
    logic [7:0]               ctrl;
    logic                     tdo;
    logic                     tdo_oe;
    logic                     irq;
    logic                     core_rst;
    logic [1:0]               warm;
    logic                     hw_sel;
    logic                     stress_sel;
  } tapid_s_t;

  tapid_s_t s_q;
  tapid_s_t s_d;

  logic [2:0] pins;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;

  // Pins pass two flops before use [R2]
  tapid_sync #(
    .W (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({tck_i, tms_i, tdi_i}),
    .q_o     (pins)
  );

  assign tck_s = pins[2];
  assign tms_s = pins[1];
  assign tdi_s = pins[0];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Clocks after reset until the synchronised pins show their true level
  localparam logic [1:0] SETTLE = 2'h3;

  logic rise;
  logic fall;

  always_comb
  begin
    s_d        = s_q;
    // No edge is taken while the synchroniser still shows its reset level
    rise       = tck_s & ~s_q.tck_prev & (s_q.warm == SETTLE);
    fall       = ~tck_s & s_q.tck_prev & (s_q.warm == SETTLE);
    s_d.tck_prev = tck_s;
    if (s_q.warm != SETTLE)
      s_d.warm = s_q.warm + 2'h1;
    s_d.irq      = 1'b0;
    s_d.core_rst = 1'b0;

    // Core side accesses; hardware set wins over host clear
    if (core_out_word_we_i)
      s_d.c2h = core_out_word_i;
    if (core_sleepless_we_i)
      s_d.ctrl[tapid_pkg::CTRL_SLEEPLESS] = core_sleepless_i;
    if (core_ifull_clr_i)
      s_d.ctrl[tapid_pkg::CTRL_IFULL] = 1'b0;

    // State changes only on scan clock rise [R2]
    if (rise)
    begin
      // Mode-driven transitions [R3] [R8]
      case (s_q.st)
        tapid_pkg::S_RESET:  s_d.st = tms_s ? tapid_pkg::S_RESET : tapid_pkg::S_IDLE; // [R9] [R1]
        tapid_pkg::S_IDLE:   s_d.st = tms_s ? tapid_pkg::S_DR_SEL : tapid_pkg::S_IDLE;
        tapid_pkg::S_DR_SEL: s_d.st = tms_s ? tapid_pkg::S_IR_SEL : tapid_pkg::S_DR_CAP;
        tapid_pkg::S_DR_CAP: s_d.st = tms_s ? tapid_pkg::S_DR_EX1 : tapid_pkg::S_DR_SH;
        tapid_pkg::S_DR_SH:  s_d.st = tms_s ? tapid_pkg::S_DR_EX1 : tapid_pkg::S_DR_SH;
        tapid_pkg::S_DR_EX1: s_d.st = tms_s ? tapid_pkg::S_DR_UPD : tapid_pkg::S_DR_PAU;
        tapid_pkg::S_DR_PAU: s_d.st = tms_s ? tapid_pkg::S_DR_EX2 : tapid_pkg::S_DR_PAU;
        tapid_pkg::S_DR_EX2: s_d.st = tms_s ? tapid_pkg::S_DR_UPD : tapid_pkg::S_DR_SH;
        tapid_pkg::S_DR_UPD: s_d.st = tms_s ? tapid_pkg::S_DR_SEL : tapid_pkg::S_IDLE;
        tapid_pkg::S_IR_SEL: s_d.st = tms_s ? tapid_pkg::S_RESET : tapid_pkg::S_IR_CAP;
        tapid_pkg::S_IR_CAP: s_d.st = tms_s ? tapid_pkg::S_IR_EX1 : tapid_pkg::S_IR_SH;
        tapid_pkg::S_IR_SH:  s_d.st = tms_s ? tapid_pkg::S_IR_EX1 : tapid_pkg::S_IR_SH;
        tapid_pkg::S_IR_EX1: s_d.st = tms_s ? tapid_pkg::S_IR_UPD : tapid_pkg::S_IR_PAU;
        tapid_pkg::S_IR_PAU: s_d.st = tms_s ? tapid_pkg::S_IR_EX2 : tapid_pkg::S_IR_PAU;
        tapid_pkg::S_IR_EX2: s_d.st = tms_s ? tapid_pkg::S_IR_UPD : tapid_pkg::S_IR_SH;
        tapid_pkg::S_IR_UPD: s_d.st = tms_s ? tapid_pkg::S_DR_SEL : tapid_pkg::S_IDLE;
        default:             s_d.st = tapid_pkg::S_RESET;
      endcase

      case (s_q.st)
        tapid_pkg::S_RESET:
        begin
          s_d.ir         = tapid_pkg::IR_RESET_VAL;
          s_d.hw_sel     = 1'b0;
          s_d.stress_sel = 1'b0;
        end
        tapid_pkg::S_IR_CAP:
        begin
          // Fixed pattern plus low control bits [R21] [R12]
          s_d.ir_sh = {s_q.ctrl[2:0], tapid_pkg::IR_CAPTURE_FIX};
        end
        tapid_pkg::S_IR_SH:
        begin
          s_d.ir_sh = {tdi_s, s_q.ir_sh[4:1]}; // [R4] [R11]
        end
        tapid_pkg::S_IR_UPD:
        begin
          s_d.ir = s_q.ir_sh; // [R11] [R15]
          s_d.hw_sel     = (s_q.ir_sh == tapid_pkg::OP_HW_TEST_SEL); // [R20]
          s_d.stress_sel = (s_q.ir_sh == tapid_pkg::OP_PRIV_STRESS);
          if (s_q.ir_sh == tapid_pkg::OP_CORE_RESET)
            s_d.core_rst = 1'b1; // [R17]
        end
        tapid_pkg::S_DR_CAP:
        begin
          // Selected register loaded into shift stage [R10] [R12]
          if (s_q.ir == tapid_pkg::OP_SEL_H2C)
            s_d.dr_sh = {1'b0, s_q.h2c};
          else if (s_q.ir == tapid_pkg::OP_SEL_C2H)
            s_d.dr_sh = {1'b0, s_q.c2h};
          else if (s_q.ir == tapid_pkg::OP_SEL_IFLAG)
            s_d.dr_sh = {s_q.ctrl[tapid_pkg::CTRL_IFULL], s_q.h2c}; // [R18]
          else if (s_q.ir == tapid_pkg::OP_SEL_OFLAG)
            s_d.dr_sh = {s_q.ctrl[tapid_pkg::CTRL_OFULL], s_q.c2h}; // [R19]
          else if (s_q.ir == tapid_pkg::OP_SEL_CTRL)
            s_d.dr_sh = {25'h0000000, s_q.ctrl};
          else
            s_d.dr_sh = '0; // Bypass and dummy boundary capture zero [R23] [R16]
        end
        tapid_pkg::S_DR_SH:
        begin
          // Shift entry point set by selected length [R5] [R22]
          if (s_q.ir == tapid_pkg::OP_SEL_H2C || s_q.ir == tapid_pkg::OP_SEL_C2H)
            s_d.dr_sh = {1'b0, tdi_s, s_q.dr_sh[31:1]};
          else if (s_q.ir == tapid_pkg::OP_SEL_IFLAG || s_q.ir == tapid_pkg::OP_SEL_OFLAG)
            s_d.dr_sh = {tdi_s, s_q.dr_sh[32:1]};
          else if (s_q.ir == tapid_pkg::OP_SEL_CTRL)
            s_d.dr_sh = {25'h0000000, tdi_s, s_q.dr_sh[7:1]};
          else
            s_d.dr_sh = {32'h00000000, tdi_s}; // [R23]
        end
        tapid_pkg::S_DR_UPD:
        begin
          if (s_q.ir == tapid_pkg::OP_SEL_H2C)
            s_d.h2c = s_q.dr_sh[31:0];
          else if (s_q.ir == tapid_pkg::OP_SEL_IFLAG)
          begin
            s_d.h2c = s_q.dr_sh[31:0];
            if (s_q.dr_sh[32])
            begin
              s_d.ctrl[tapid_pkg::CTRL_IFULL] = 1'b1; // [R14]
              s_d.irq = 1'b1;
            end
          end
          else if (s_q.ir == tapid_pkg::OP_SEL_OFLAG)
          begin
            // Word is read-only, flag one clears [R13] [R14]
            if (s_q.dr_sh[32] && !core_ofull_set_i)
              s_d.ctrl[tapid_pkg::CTRL_OFULL] = 1'b0;
          end
          else if (s_q.ir == tapid_pkg::OP_SEL_CTRL)
          begin
            if (s_q.dr_sh[tapid_pkg::CTRL_OFULL] && !core_ofull_set_i)
              s_d.ctrl[tapid_pkg::CTRL_OFULL] = 1'b0; // [R14]
            if (s_q.dr_sh[tapid_pkg::CTRL_IFULL])
            begin
              s_d.ctrl[tapid_pkg::CTRL_IFULL] = 1'b1;
              s_d.irq = 1'b1;
            end
            s_d.ctrl[tapid_pkg::CTRL_SLEEPLESS] = s_q.dr_sh[tapid_pkg::CTRL_SLEEPLESS];
          end
        end
        default:
        begin
        end
      endcase
    end

    if (core_ofull_set_i)
      s_d.ctrl[tapid_pkg::CTRL_OFULL] = 1'b1;

    // Output changes on falling edge only [R6] [R7]
    if (fall)
    begin
      s_d.tdo_oe = 1'b0;
      s_d.tdo    = 1'b0;
      if (s_q.st == tapid_pkg::S_IR_SH)
      begin
        s_d.tdo_oe = 1'b1;
        s_d.tdo    = s_q.ir_sh[0];
      end
      else if (s_q.st == tapid_pkg::S_DR_SH)
      begin
        s_d.tdo_oe = 1'b1;
        s_d.tdo    = s_q.dr_sh[0]; // [R5]
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_q          <= '0;
      s_q.st       <= tapid_pkg::S_RESET; // [R9]
      s_q.ir       <= tapid_pkg::IR_RESET_VAL;
      s_q.ctrl     <= tapid_pkg::CTRL_RESET_VAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tdo_o                  = s_q.tdo;
  assign tdo_oe_o               = s_q.tdo_oe;
  assign host_in_word_o         = s_q.h2c;
  assign core_out_word_o        = s_q.c2h;
  assign ifull_o                = s_q.ctrl[tapid_pkg::CTRL_IFULL];
  assign ofull_o                = s_q.ctrl[tapid_pkg::CTRL_OFULL];
  assign sleepless_o            = s_q.ctrl[tapid_pkg::CTRL_SLEEPLESS];
  assign host_irq_o             = s_q.irq;
  assign core_reset_o           = s_q.core_rst; // [R17]
  assign hardware_test_select_o = s_q.hw_sel; // [R20]
  assign private_stress_op_o    = s_q.stress_sel;

endmodule
`default_nettype wire

// >>> tapid_pkg.sv
// Constants and types shared by the test access port design
package tapid_pkg;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  localparam int unsigned IR_W       = 5;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned CTRL_W     = 8;
  localparam int unsigned BSR_W      = 1;

  localparam logic [4:0] OP_EXTEST       = 5'h00;
  localparam logic [4:0] OP_SAMPLE       = 5'h01;
  localparam logic [4:0] OP_BYPASS       = 5'h1f;
  localparam logic [4:0] OP_CORE_RESET   = 5'h10;
  localparam logic [4:0] OP_SEL_H2C      = 5'h11;
  localparam logic [4:0] OP_SEL_C2H      = 5'h12;
  localparam logic [4:0] OP_SEL_IFLAG    = 5'h13;
  localparam logic [4:0] OP_SEL_OFLAG    = 5'h14;
  localparam logic [4:0] OP_SEL_CTRL     = 5'h15;
  localparam logic [4:0] OP_HW_TEST_SEL  = 5'h1e;
  localparam logic [4:0] OP_PRIV_STRESS  = 5'h0a;
  localparam logic [4:0] OP_PRIV_PASS    = 5'h0e;

  localparam logic [1:0] IR_CAPTURE_FIX  = 2'h1;
  localparam logic [4:0] IR_RESET_VAL    = OP_BYPASS;

  // Handshake control bit positions
  localparam int unsigned CTRL_OFULL     = 0;
  localparam int unsigned CTRL_IFULL     = 1;
  localparam int unsigned CTRL_SLEEPLESS = 2;
  localparam logic [7:0]  CTRL_RESET_VAL = 8'h04;

  // ---------------------------------------------------------------
  // Controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [15:0] {
    S_RESET   = 16'h0001,
    S_IDLE    = 16'h0002,
    S_DR_SEL  = 16'h0004,
    S_DR_CAP  = 16'h0008,
    S_DR_SH   = 16'h0010,
    S_DR_EX1  = 16'h0020,
    S_DR_PAU  = 16'h0040,
    S_DR_EX2  = 16'h0080,
    S_DR_UPD  = 16'h0100,
    S_IR_SEL  = 16'h0200,
    S_IR_CAP  = 16'h0400,
    S_IR_SH   = 16'h0800,
    S_IR_EX1  = 16'h1000,
    S_IR_PAU  = 16'h2000,
    S_IR_EX2  = 16'h4000,
    S_IR_UPD  = 16'h8000
  } tapid_state_t;

endpackage

// >>> tapid_sync.sv
// Two-flop synchroniser for the scan pins
`timescale 1ns/1ps
`default_nettype none
module tapid_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// >>> tapid_properties.sv
// Concurrent checks on the test access port outputs
`timescale 1ns/1ps
`default_nettype none
module tapid_properties (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        tck_i,
  input wire logic        tdo_o,
  input wire logic        tdo_oe_o,
  input wire logic [31:0] core_out_word_i,
  input wire logic        core_out_word_we_i,
  input wire logic        core_ofull_set_i,
  input wire logic        core_sleepless_i,
  input wire logic        core_sleepless_we_i,
  input wire logic [31:0] host_in_word_o,
  input wire logic [31:0] core_out_word_o,
  input wire logic        ifull_o,
  input wire logic        ofull_o,
  input wire logic        sleepless_o,
  input wire logic        host_irq_o,
  input wire logic        core_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------
  // Scan clock level over the last two clocks
  // ------------------------------------------------
  sequence s_tck_low;
    !$past(tck_i) && !$past(tck_i, 2);
  endsequence
  sequence s_tck_high;
    $past(tck_i) && $past(tck_i, 2);
  endsequence
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> s_tck_low)
    else $error("serial output moved while scan clock high");
  a_oe_on_fall: assert property ($rose(tdo_oe_o) |-> s_tck_low)
    else $error("output enable rose while scan clock high");
  a_idle_out_low: assert property (!tdo_oe_o |-> !tdo_o)
    else $error("serial output high while not driven");
  a_hin_on_rise: assert property ($changed(host_in_word_o) |-> s_tck_high)
    else $error("host word changed away from a scan clock rise");
  a_cout_read_only: assert property ($changed(core_out_word_o) |-> $past(core_out_word_we_i) || $past(core_reset_o))
    else $error("core word changed without a core write");
  a_cout_load: assert property (core_out_word_we_i |=> core_out_word_o == $past(core_out_word_i))
    else $error("core word not loaded");
  a_ofull_set: assert property (core_ofull_set_i |=> ofull_o)
    else $error("output full not set by core");
  a_irq_sets_ifull: assert property (host_irq_o |-> ##[0:1] ifull_o)
    else $error("host interrupt without input full");
  a_irq_one_pulse: assert property (host_irq_o |=> !host_irq_o)
    else $error("host interrupt longer than one clock");
  a_reset_pulse: assert property (core_reset_o |=> !core_reset_o)
    else $error("core reset longer than one clock");
  a_sleep_write: assert property (core_sleepless_we_i |=> sleepless_o == $past(core_sleepless_i))
    else $error("sleepless bit not written by core");
endmodule
bind tapid_top tapid_properties chk_u (.clk_i, .rst_n_i, .tck_i, .tdo_o, .tdo_oe_o, .core_out_word_i,
  .core_out_word_we_i, .core_ofull_set_i, .core_sleepless_i, .core_sleepless_we_i, .host_in_word_o,
  .core_out_word_o, .ifull_o, .ofull_o, .sleepless_o, .host_irq_o, .core_reset_o);
`default_nettype wire

// >>> tapid_host.sv
// Behavioural scan host that clocks the test port
`timescale 1ns/1ps
`default_nettype none
module tapid_host (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial
  begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One scan clock period: drive after the fall, sample at the rise
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge clk_i);
    tck_o = 1'b0;
    tms_o = m;
    tdi_o = d;
    repeat (4) @(negedge clk_i);
    o = tdo_i;
    tck_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic tlr;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Clock stands still high between frames; data line shows a stale-inverted level
  task automatic scan(input logic ir, input logic [47:0] din, input int n, output logic [47:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    // Let the update reach the registered outputs before anyone looks
    repeat (2) @(negedge clk_i);
    tdi_o = ~tdi_o;
  endtask
endmodule
`default_nettype wire

// >>> tb_tapid_top.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module tb_tapid_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
  logic [31:0] core_out_word_i = '0, host_in_word_o, core_out_word_o;
  logic core_out_word_we_i = 1'b0, core_ofull_set_i = 1'b0, core_ifull_clr_i = 1'b0;
  logic core_sleepless_i = 1'b0, core_sleepless_we_i = 1'b0, ifull_o, ofull_o, sleepless_o;
  logic host_irq_o, core_reset_o, hardware_test_select_o, private_stress_op_o;
  logic [47:0] din, dout, exp, mask;
  logic [4:0] op;
  logic [4:0] ops[$] = '{5'h1f, 5'h00, 5'h01, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1e, 5'h0a, 5'h0e, 5'h07, 5'h10};
  int mismatches = 0, check_count = 0, crst_seen = 0, len, m_ctrl = 4, irq_seen = 0, m_irq = 0;
  int unsigned m_hin = 0, m_cout = 0;
  wire tdo_w = tdo_oe_o ? tdo_o : 1'bz;
  tapid_top dut_u (.clk_i, .rst_n_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .core_out_word_i,
    .core_out_word_we_i, .core_ofull_set_i, .core_ifull_clr_i, .core_sleepless_i, .core_sleepless_we_i,
    .host_in_word_o, .core_out_word_o, .ifull_o, .ofull_o, .sleepless_o, .host_irq_o, .core_reset_o,
    .hardware_test_select_o, .private_stress_op_o);
  tapid_host host_u (.clk_i, .tdo_i(tdo_w), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (core_reset_o === 1'b1)
      crst_seen++;
    if (host_irq_o === 1'b1)
      irq_seen++;
  end
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1ms;
    mismatches++;
    stop_test();
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    void'($urandom(78));
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    core_out_word_i = $urandom;
    core_out_word_we_i = 1'b1;
    core_ofull_set_i = 1'b1;
    @(negedge clk_i);
    core_out_word_we_i = 1'b0;
    core_ofull_set_i = 1'b0;
    m_cout = core_out_word_i;
    m_ctrl = m_ctrl | 1;
    host_u.tlr();
    foreach (ops[k])
    begin
      op = ops[k];
      len = (op == 5'h11 || op == 5'h12) ? 32 : (op == 5'h13 || op == 5'h14) ? 33 : (op == 5'h15) ? 8 : 1;
      host_u.scan(1'b1, {43'h0, op}, 5, dout);
      chk("ir_capture", dout[4:0], {m_ctrl[2:0], 2'h1});
      chk("test_sel", {hardware_test_select_o, private_stress_op_o}, {op == 5'h1e, op == 5'h0a});
      chk("core_reset", crst_seen, op == 5'h10);
      din = 48'({$urandom, $urandom});
      if (op == 5'h13)
        din[40] = 1'b1;
      if (op == 5'h14)
        din[40] = 1'b0;
      if (op == 5'h15)
        din[15:8] = 8'h01;
      host_u.scan(1'b0, din, len + 8, dout);
      for (int i = len; i < len + 8; i++)
        chk("delay", dout[i], din[i - len]);
      exp = '0;
      mask = (len == 1) ? 48'h1 : '0;
      if (len >= 32)
      begin
        exp = (op == 5'h11 || op == 5'h13) ? {m_ctrl[1], m_hin} : {m_ctrl[0], m_cout};
        mask = {len == 33, 32'hffffffff};
      end
      if (op == 5'h15)
      begin
        exp = 48'(m_ctrl);
        mask = 48'h7;
      end
      chk("captured", dout & mask, exp & mask);
      if (op == 5'h11 || op == 5'h13)
        m_hin = din[39:8];
      if (op == 5'h13)
        m_ctrl = m_ctrl | 2;
      if (op == 5'h15)
        m_ctrl = m_ctrl & 2;
      if (op == 5'h13)
        m_irq++;
      chk("host_irq", irq_seen, m_irq);
      if (op != 5'h10)
        chk("state", {host_in_word_o, core_out_word_o, sleepless_o, ifull_o, ofull_o}, {m_hin, m_cout, m_ctrl[2:0]});
    end
    @(negedge clk_i);
    core_ifull_clr_i = 1'b1;
    core_sleepless_i = 1'b1;
    core_sleepless_we_i = 1'b1;
    @(negedge clk_i);
    core_ifull_clr_i = 1'b0;
    core_sleepless_we_i = 1'b0;
    @(negedge clk_i);
    chk("core_side", {ifull_o, sleepless_o}, 2'h1);
    host_u.tlr();
    din = 48'($urandom);
    host_u.scan(1'b0, din, 9, dout);
    chk("bypass_after_tlr", dout[8:0], {din[7:0], 1'b0});
    stop_test();
  end
endmodule
`default_nettype wire
